// >>> rtl/tdw_pkg.sv
// Operation
// R1: Warning threshold exponent fixed at zero
// R2: Warning threshold resets to 100 degrees
// R3: Warning threshold mantissa stays within 100..140
// R4: Turn-on delay spans start to rise
// R5: Turn-on delay saved on store-all command
// R6: Turn-on delay exponent fixed zero, millisecond units
// R7: Delay upper bits zero, low seven writable
// R8: Exactly sixteen effective turn-on delays exist
// R9: Low mantissas map to 50us up to 14ms
// R10: Higher mantissas map 19ms up to 100ms
// R11: Warning at or above fault rejected, flagged
// R12: Fixed bits read zero, writes ignored
package tdw_pkg;
    // Command codes
    localparam logic [7:0]  CMD_WARN_LIMIT  = 8'h51;
    localparam logic [7:0]  CMD_TURN_ON     = 8'h60;
    localparam logic [7:0]  CMD_STORE_ALL   = 8'h11;
    // Word layout
    localparam int          EXP_LSB         = 11;
    localparam int          MANT_W          = 11;
    localparam int          DLY_W           = 7;
    // Reset values
    localparam logic [10:0] WARN_RESET      = 11'h064;
    localparam logic [6:0]  DLY_RESET       = 7'h00;
    // Warning mantissa bounds
    localparam logic [10:0] WARN_MIN        = 11'h064;
    localparam logic [10:0] WARN_MAX        = 11'h08C;
    // Timing, from a 4 ns clock
    localparam int          CLK_PERIOD_PS   = 4000;
    localparam int          MS_PS           = 1000000000;
    localparam int          SHORT_DLY_US    = 50;
    localparam int          MS_CYC          = MS_PS / CLK_PERIOD_PS;
    localparam int          SHORT_CYC       = SHORT_DLY_US * 1000000 / CLK_PERIOD_PS;
    // Delay sequencer states
    typedef enum logic [0:0] {
        TDW_IDLE = 1'b0,
        TDW_WAIT = 1'b1
    } tdw_state_t;

    // Effective delay in ms for a programmed mantissa (0 means the short delay)
    function automatic logic [6:0] tdw_eff_ms(input logic [6:0] m);
        logic [6:0] r;
        r = 7'h00;
        if (m <= 7'h06) begin
            r = m;
        end else if (m <= 7'h09) begin
            r = 7'h07;
        end else if (m <= 7'h0C) begin
            r = 7'h0A;
        end else if (m <= 7'h11) begin
            r = 7'h0E;
        end else if (m <= 7'h16) begin
            r = 7'h13;
        end else if (m <= 7'h20) begin
            r = 7'h1B;
        end else if (m <= 7'h2C) begin
            r = 7'h25;
        end else if (m <= 7'h3E) begin
            r = 7'h34;
        end else if (m <= 7'h56) begin
            r = 7'h48;
        end else begin
            r = 7'h64;
        end
        return r;
    endfunction
endpackage

// >>> rtl/tdw_regs.sv
`timescale 1ns/10ps
module tdw_regs
    import tdw_pkg::*;
#(
    parameter int MS_CYCLES    = MS_CYC,
    parameter int SHORT_CYCLES = SHORT_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Decoded command port
    input  wire logic [7:0]  cmd_code,
    input  wire logic        cmd_wr,
    input  wire logic        cmd_rd,
    input  wire logic [15:0] cmd_wdata,
    output logic [15:0]      cmd_rdata,
    output logic             cmd_rvalid,
    output logic             cmd_invalid,
    // Fault threshold from the fault block
    input  wire logic [10:0] overtemp_fault_threshold,
    // Warning threshold to the comparator
    output logic [10:0]      warn_threshold,
    // Non-volatile save request
    output logic             nvm_save,
    output logic [15:0]      nvm_save_word,
    // Sequencer handshake
    input  wire logic        start_req,
    output logic             rise_go
);

    // Register state
    logic [10:0] warn_q, warn_d;       // Warning mantissa
    logic [6:0]  dly_q, dly_d;         // Turn-on delay mantissa
    logic [15:0] rdata_q, rdata_d;     // Read answer
    logic        rvalid_q, rvalid_d;   // Read answer valid
    logic        inval_q, inval_d;     // Rejected write pulse
    logic        save_q, save_d;       // Save pulse
    logic [15:0] sword_q, sword_d;     // Saved word
    logic        warn_ok;              // Warning write acceptable

    // Range and relation check on a warning write
    always_comb begin
        warn_ok = (cmd_wdata[MANT_W-1:0] >= WARN_MIN)
               && (cmd_wdata[MANT_W-1:0] <= WARN_MAX)
               && (cmd_wdata[MANT_W-1:0] < overtemp_fault_threshold);
    end

    // Next state of the register file
    always_comb begin
        warn_d   = warn_q;
        dly_d    = dly_q;
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        inval_d  = 1'b0;
        save_d   = 1'b0;
        sword_d  = sword_q;
        if (cmd_wr) begin
            if (cmd_code == CMD_WARN_LIMIT) begin
                // R11: reject and flag
                if (!warn_ok) begin
                    inval_d = 1'b1;
                end else begin
                    // R3: accepted only in range; R1: exponent ignored
                    warn_d = cmd_wdata[MANT_W-1:0];
                end
            end else if (cmd_code == CMD_TURN_ON) begin
                // R7: only low seven bits stored
                dly_d = cmd_wdata[DLY_W-1:0];
            end else if (cmd_code == CMD_STORE_ALL) begin
                // R5: hand delay word to storage
                save_d  = 1'b1;
                sword_d = {9'h000, dly_q};
            end
        end
        if (cmd_rd) begin
            rvalid_d = 1'b1;
            // R12: fixed fields read as zero
            if (cmd_code == CMD_WARN_LIMIT) begin
                rdata_d = {5'h00, warn_q};
            end else if (cmd_code == CMD_TURN_ON) begin
                // R6: exponent zero, millisecond units
                rdata_d = {9'h000, dly_q};
            end else begin
                rdata_d = 16'h0000;
            end
        end
    end

    // Register file flops
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            // R2: warning defaults to 100
            warn_q   <= WARN_RESET;
            dly_q    <= DLY_RESET;
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
            inval_q  <= 1'b0;
            save_q   <= 1'b0;
            sword_q  <= 16'h0000;
        end else begin
            warn_q   <= warn_d;
            dly_q    <= dly_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            inval_q  <= inval_d;
            save_q   <= save_d;
            sword_q  <= sword_d;
        end
    end

    assign cmd_rdata      = rdata_q;
    assign cmd_rvalid     = rvalid_q;
    assign cmd_invalid    = inval_q;
    assign warn_threshold = warn_q;
    assign nvm_save       = save_q;
    assign nvm_save_word  = sword_q;

    // Delay sequencer state
    tdw_state_t  state_q, state_d;     // Sequencer state
    logic [31:0] cnt_q, cnt_d;         // Remaining cycles
    logic        go_q, go_d;           // Rise start pulse
    logic [31:0] load_cyc;             // Cycles for the current setting
    logic [6:0]  eff_ms;               // Effective delay in ms

    // R8: sixteen buckets; R9: short end; R10: long end
    always_comb begin
        eff_ms = tdw_eff_ms(dly_q);
        if (eff_ms == 7'h00) begin
            load_cyc = 32'(SHORT_CYCLES);
        end else begin
            load_cyc = 32'(eff_ms) * 32'(MS_CYCLES);
        end
    end

    // Next state of the sequencer
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        go_d    = 1'b0;
        unique case (state_q)
            TDW_IDLE: begin
                // R4: wait begins at start
                if (start_req) begin
                    state_d = TDW_WAIT;
                    cnt_d   = load_cyc - 32'h0000_0001;
                end
            end
            TDW_WAIT: begin
                // Count down, then let the output rise
                if (cnt_q == 32'h0000_0000) begin
                    state_d = TDW_IDLE;
                    go_d    = 1'b1;
                end else begin
                    cnt_d = cnt_q - 32'h0000_0001;
                end
            end
        endcase
    end

    // Sequencer flops
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_q <= TDW_IDLE;
            cnt_q   <= 32'h0000_0000;
            go_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            go_q    <= go_d;
        end
    end

    assign rise_go = go_q;

    // Helper: elapsed cycles and expected wait since start
    logic [31:0] el_q, el_d;
    logic [31:0] exp_q, exp_d;
    // Next values of the helper counters
    always_comb begin
        el_d  = el_q;
        exp_d = exp_q;
        if (state_q == TDW_IDLE && start_req) begin
            el_d  = 32'h0000_0000;
            exp_d = load_cyc;
        end else if (state_q == TDW_WAIT) begin
            el_d = el_q + 32'h0000_0001;
        end
    end
    // Helper flops
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            el_q  <= 32'h0000_0000;
            exp_q <= 32'h0000_0000;
        end else begin
            el_q  <= el_d;
            exp_q <= exp_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // Steps of a bad warning write
    sequence bad_warn_s;
        cmd_wr && cmd_code == CMD_WARN_LIMIT
            && cmd_wdata[MANT_W-1:0] >= overtemp_fault_threshold;
    endsequence
    // Warning write outside the allowed span
    sequence out_range_s;
        cmd_wr && cmd_code == CMD_WARN_LIMIT
            && (cmd_wdata[MANT_W-1:0] < WARN_MIN || cmd_wdata[MANT_W-1:0] > WARN_MAX);
    endsequence
    // Warning write that must be taken
    sequence good_warn_s;
        cmd_wr && cmd_code == CMD_WARN_LIMIT
            && cmd_wdata[MANT_W-1:0] >= WARN_MIN && cmd_wdata[MANT_W-1:0] <= WARN_MAX
            && cmd_wdata[MANT_W-1:0] < overtemp_fault_threshold;
    endsequence
    // Rejection seen one cycle later
    sequence flagged_s;
        cmd_invalid && $stable(warn_threshold);
    endsequence

    // Write side of the warning register
    warn_reject_a: assert property (bad_warn_s |=> flagged_s) // R11
        else $error("bad warning write not rejected");
    span_reject_a: assert property (out_range_s |=> flagged_s) // R3
        else $error("out of span warning write not rejected");
    warn_take_a: assert property ( // R3
        good_warn_s |=> !cmd_invalid && warn_threshold == $past(cmd_wdata[MANT_W-1:0]))
        else $error("good warning write not taken");
    flag_source_a: assert property ( // R11
        cmd_invalid |-> $past(cmd_wr) && $past(cmd_code) == CMD_WARN_LIMIT)
        else $error("invalid flag without a warning write");
    warn_range_a: assert property ( // R3
        warn_threshold >= WARN_MIN && warn_threshold <= WARN_MAX)
        else $error("warning threshold out of range");
    warn_reset_a: assert property (!$past(reset_n) |-> warn_threshold == WARN_RESET) // R2
        else $error("warning reset value wrong");
    // Read side and fixed fields
    read_valid_a: assert property (cmd_rd |=> cmd_rvalid) // R12
        else $error("read not answered");
    read_exp_a: assert property (cmd_rvalid |-> cmd_rdata[15:EXP_LSB] == 5'h00) // R1
        else $error("exponent not zero on read");
    read_warn_a: assert property ( // R12
        cmd_rd && cmd_code == CMD_WARN_LIMIT |=> cmd_rdata == {5'h00, $past(warn_threshold)})
        else $error("warning read does not match stored value");
    dly_upper_a: assert property ( // R7
        cmd_rd && cmd_code == CMD_TURN_ON |=> cmd_rdata[15:DLY_W] == 9'h000)
        else $error("delay upper bits not zero");
    dly_write_a: assert property ( // R7
        cmd_wr && cmd_code == CMD_TURN_ON |=> dly_q == $past(cmd_wdata[DLY_W-1:0]))
        else $error("delay write not stored");
    // Storage hand-off
    save_word_a: assert property ( // R5
        cmd_wr && cmd_code == CMD_STORE_ALL
            |=> nvm_save && nvm_save_word == {9'h000, $past(dly_q)})
        else $error("store-all did not save delay");
    save_source_a: assert property ( // R5
        nvm_save |-> $past(cmd_wr) && $past(cmd_code) == CMD_STORE_ALL)
        else $error("save pulse without store-all");
    // Turn-on wait length and pulse
    wait_len_a: assert property (rise_go |-> el_q == exp_q) // R4
        else $error("turn-on wait length wrong");
    go_pulse_a: assert property (rise_go |-> state_q == TDW_IDLE ##1 !rise_go) // R4
        else $error("rise pulse too long");
    late_start_a: assert property ( // R4
        state_q == TDW_WAIT && start_req && cnt_q != 32'h0000_0000
            |=> state_q == TDW_WAIT && cnt_q == $past(cnt_q) - 32'h0000_0001)
        else $error("start during wait disturbed the count");
    // Bucket map, one property per mantissa range, plus a second property for mantissa 8
    map_zero_a: assert property ( // R8
        state_q == TDW_IDLE && start_req && dly_q == 7'h00
            |=> exp_q == 32'(SHORT_CYCLES))
        else $error("zero mantissa not mapped to short delay");
    map_low_a: assert property ( // R9
        state_q == TDW_IDLE && start_req && dly_q >= 7'h01 && dly_q <= 7'h06
            |=> exp_q == 32'($past(dly_q)) * 32'(MS_CYCLES))
        else $error("low mantissa not mapped to its own ms");
    map_seven_a: assert property ( // R9
        state_q == TDW_IDLE && start_req && dly_q >= 7'h07 && dly_q <= 7'h09
            |=> exp_q == 32'(7 * MS_CYCLES))
        else $error("mantissa 7 to 9 not mapped to 7 ms");
    map_mid_a: assert property ( // R9
        state_q == TDW_IDLE && start_req && dly_q == 7'h08
            |=> exp_q == 32'(7 * MS_CYCLES))
        else $error("mantissa 8 not mapped to 7 ms");
    map_ten_a: assert property ( // R9
        state_q == TDW_IDLE && start_req && dly_q >= 7'h0A && dly_q <= 7'h0C
            |=> exp_q == 32'(10 * MS_CYCLES))
        else $error("mantissa 10 to 12 not mapped to 10 ms");
    map_fourteen_a: assert property ( // R9
        state_q == TDW_IDLE && start_req && dly_q >= 7'h0D && dly_q <= 7'h11
            |=> exp_q == 32'(14 * MS_CYCLES))
        else $error("mantissa 13 to 17 not mapped to 14 ms");
    map_nineteen_a: assert property ( // R10
        state_q == TDW_IDLE && start_req && dly_q >= 7'h12 && dly_q <= 7'h16
            |=> exp_q == 32'(19 * MS_CYCLES))
        else $error("mantissa 18 to 22 not mapped to 19 ms");
    map_twentyseven_a: assert property ( // R10
        state_q == TDW_IDLE && start_req && dly_q >= 7'h17 && dly_q <= 7'h20
            |=> exp_q == 32'(27 * MS_CYCLES))
        else $error("mantissa 23 to 32 not mapped to 27 ms");
    map_thirtyseven_a: assert property ( // R10
        state_q == TDW_IDLE && start_req && dly_q >= 7'h21 && dly_q <= 7'h2C
            |=> exp_q == 32'(37 * MS_CYCLES))
        else $error("mantissa 33 to 44 not mapped to 37 ms");
    map_fiftytwo_a: assert property ( // R10
        state_q == TDW_IDLE && start_req && dly_q >= 7'h2D && dly_q <= 7'h3E
            |=> exp_q == 32'(52 * MS_CYCLES))
        else $error("mantissa 45 to 62 not mapped to 52 ms");
    map_seventytwo_a: assert property ( // R10
        state_q == TDW_IDLE && start_req && dly_q >= 7'h3F && dly_q <= 7'h56
            |=> exp_q == 32'(72 * MS_CYCLES))
        else $error("mantissa 63 to 86 not mapped to 72 ms");
    map_top_a: assert property ( // R10
        state_q == TDW_IDLE && start_req && dly_q > 7'h56
            |=> exp_q == 32'(100 * MS_CYCLES))
        else $error("high mantissa not mapped to 100 ms");

endmodule

// >>> tb/tdw_host.sv
`timescale 1ns/10ps
module tdw_host (
    // Clock
    input  wire logic        sys_clk,
    // Command port toward the device
    output logic [7:0]       cmd_code,
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic [15:0]      cmd_wdata
);
    // Idle port at time zero
    initial begin
        cmd_code  = 8'h00;
        cmd_wr    = 1'b0;
        cmd_rd    = 1'b0;
        cmd_wdata = 16'h0000;
    end
    task automatic write(input logic [7:0] code, input logic [15:0] data);
        @(negedge sys_clk);
        cmd_code  = code;
        cmd_wdata = data;
        cmd_wr    = 1'b1;
        @(negedge sys_clk);
        cmd_wr    = 1'b0;
        // Released data no longer shows the word
        cmd_wdata = ~data;
    endtask
    // One read strobe, one taking edge
    task automatic read(input logic [7:0] code);
        @(negedge sys_clk);
        cmd_code = code;
        cmd_rd   = 1'b1;
        @(negedge sys_clk);
        cmd_rd   = 1'b0;
    endtask
endmodule

// >>> tb/tdw_regs_test.sv
`timescale 1ns/10ps
module tdw_regs_test;
    import tdw_pkg::*;
    // Shortened counts and bucket table
    localparam int MS_N    = 4;
    localparam int SH_N    = 2;
    localparam int UB[16]  = '{0, 1, 2, 3, 4, 5, 6, 9, 12, 17, 22, 32, 44, 62, 86, 127};
    localparam int EFF[16] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 14, 19, 27, 37, 52, 72, 100};
    // Design signals
    logic        sys_clk, reset_n, cmd_wr, cmd_rd, cmd_rvalid, cmd_invalid;
    logic        nvm_save, start_req, rise_go;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, nvm_save_word;
    logic [10:0] fault_thr, warn_threshold, warn_m;
    logic [6:0]  dm;
    // Expected reads and counters
    logic [15:0] exp_q[$];
    int          n_errors, comparisons, cnt, b;

    tdw_regs #(.MS_CYCLES(MS_N), .SHORT_CYCLES(SH_N)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n),
        .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .cmd_invalid(cmd_invalid),
        .overtemp_fault_threshold(fault_thr), .warn_threshold(warn_threshold),
        .nvm_save(nvm_save), .nvm_save_word(nvm_save_word),
        .start_req(start_req), .rise_go(rise_go)
    );
    tdw_host host (.sys_clk(sys_clk), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata));

    // 4 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Counted comparison
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Note the answer, then read
    task automatic rd_exp(input logic [7:0] code, input logic [15:0] e);
        exp_q.push_back(e);
        host.read(code);
    endtask
    // Warning write with its expected outcome
    task automatic wwarn(input logic [15:0] d);
        logic bad;
        bad = (d[10:0] < WARN_MIN) || (d[10:0] > WARN_MAX) || (d[10:0] >= fault_thr);
        host.write(CMD_WARN_LIMIT, d);
        check({15'h0000, cmd_invalid}, {15'h0000, bad}, "reject flag");
        warn_m = bad ? warn_m : d[10:0];
        check({5'h00, warn_threshold}, {5'h00, warn_m}, "warn value");
        rd_exp(CMD_WARN_LIMIT, {5'h00, warn_m});
    endtask
    // Delay write with junk in fixed bits
    task automatic wdly(input logic [6:0] m);
        host.write(CMD_TURN_ON, {9'($urandom), m});
        rd_exp(CMD_TURN_ON, {9'h000, m});
    endtask
    // Counts and verdict
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Oldest noted read against each answer
    always @(negedge sys_clk) begin
        if (cmd_rvalid === 1'b1) begin
            check(cmd_rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX, "read");
        end
    end

    // Hang guard
    initial begin
        #400000;
        n_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        give_verdict();
    end

    // Main sequence
    initial begin
        reset_n   = 1'b0;
        start_req = 1'b0;
        fault_thr = 11'h08D;
        warn_m    = WARN_RESET;
        void'($urandom(32'hDD804E25));
        repeat (12) @(negedge sys_clk);
        reset_n = 1'b1;
        check({5'h00, warn_threshold}, 16'h0064, "warn reset");
        check(nvm_save_word, 16'h0000, "save word reset");
        rd_exp(CMD_WARN_LIMIT, 16'h0064);
        rd_exp(CMD_TURN_ON, 16'h0000);
        rd_exp(8'h7F, 16'h0000);
        $display("test reset done");
        wwarn(16'hF88C);
        wwarn(16'h008D);
        wwarn(16'h0063);
        wwarn(16'h0064);
        fault_thr = 11'h070;
        wwarn(16'h0070);
        wwarn(16'h006F);
        fault_thr = 11'h08D;
        repeat (8) wwarn({5'($urandom), 11'($urandom_range(150, 90))});
        $display("test warning done");
        // every mantissa timed against its bucket
        for (int m = 0; m < 128; m++) begin
            wdly(7'(m));
            b = 0;
            while (UB[b] < m) b++;
            @(negedge sys_clk);
            start_req = 1'b1;
            cnt = 0;
            do begin
                @(negedge sys_clk);
                cnt++;
                // Extra start in mid-wait must be ignored
                start_req = (cnt == 2) && (EFF[b] > 0);
            end while (rise_go !== 1'b1 && cnt < 500);
            check(16'(cnt), 16'((EFF[b] == 0) ? SH_N + 1 : EFF[b] * MS_N + 1), "wait");
            @(negedge sys_clk);
            check({15'h0000, rise_go}, 16'h0000, "rise pulse");
        end
        $display("test delay map done");
        dm = 7'($urandom);
        wdly(dm);
        host.write(CMD_STORE_ALL, 16'h0000);
        check({15'h0000, nvm_save}, 16'h0001, "save pulse");
        check(nvm_save_word, {9'h000, dm}, "save word");
        $display("test store done");
        repeat (2) @(negedge sys_clk);
        give_verdict();
    end
endmodule
